// ### flm_pkg.sv
`default_nettype none
package flm_pkg;
    // Register addresses as seen by the serial write/read engine
    localparam logic [7:0] ADDR_MODE_SELECT = 8'h10;
    localparam logic [7:0] ADDR_MULTI_PIN   = 8'h20;
    localparam logic [7:0] ADDR_STEP_TIME   = 8'h50;
    localparam logic [7:0] ADDR_TORCH_LEVEL = 8'ha0;
    localparam logic [7:0] ADDR_FLASH_LEVEL = 8'hb0;
    localparam logic [7:0] ADDR_TIMEOUT     = 8'hc0;
    // Power-on values
    localparam logic [7:0] RST_MODE_SELECT  = 8'h18;
    localparam logic [7:0] RST_MULTI_PIN    = 8'he0;
    localparam logic [7:0] RST_STEP_TIME    = 8'hfc;
    localparam logic [7:0] RST_TORCH_LEVEL  = 8'h80;
    localparam logic [7:0] RST_FLASH_LEVEL  = 8'h80;
    localparam logic [7:0] RST_TIMEOUT      = 8'hf0;
    // Writable bits; the rest read back their power-on value
    localparam logic [7:0] MASK_MODE_SELECT = 8'h27;
    localparam logic [7:0] MASK_MULTI_PIN   = 8'h1f;
    localparam logic [7:0] MASK_STEP_TIME   = 8'h03;
    localparam logic [7:0] MASK_LEVEL       = 8'h7f;
    localparam logic [7:0] MASK_TIMEOUT     = 8'h0f;
    // Field positions in mode_select
    localparam int BIT_MODE_ENABLE_LO  = 0;
    localparam int BIT_MODE_ENABLE_HI  = 1;
    localparam int BIT_VOLTAGE_MODE    = 2;
    localparam int BIT_HEADROOM_SELECT = 5;
    // Field positions in multi_pin_control
    localparam int BIT_RESET_SELECT    = 0;
    localparam int BIT_PIN_DIRECTION   = 1;
    localparam int BIT_PIN_DATA        = 2;
    localparam int BIT_OVERVOLTAGE_SEL = 3;
    localparam int BIT_CURRENT_LIMIT   = 4;
    // Field widths
    localparam int LEVEL_W      = 7;
    localparam int TORCH_USE_W  = 5;
    localparam int STEP_W       = 2;
    localparam int TIMEOUT_W    = 4;
    // Mode enable codes
    localparam logic [1:0] EN_SHUTDOWN  = 2'h0;
    localparam logic [1:0] EN_INDICATOR = 2'h1;
    localparam logic [1:0] EN_TORCH     = 2'h2;
    localparam logic [1:0] EN_FLASH     = 2'h3;
    // Current code shown while the indicator runs at its fixed current
    localparam logic [6:0] INDICATOR_CODE = 7'h00;
    // Timing: clock rate and the 25 us base step
    localparam int CLK_MHZ        = 125;
    localparam int STEP_BASE_US   = 25;
    localparam int STEP_BASE_CYC  = STEP_BASE_US * CLK_MHZ;
    // Flash safety timeout in 50 ms units of base steps
    localparam int TIMEOUT_UNIT_MS    = 50;
    localparam int TIMEOUT_MIN_MS     = 50;
    localparam int TIMEOUT_STEP_MS    = 100;
    localparam int TIMEOUT_FULL_MS    = 3200;
    localparam int TIMEOUT_UNIT_TICKS = TIMEOUT_UNIT_MS * 1000 / STEP_BASE_US;
    localparam logic [3:0] TIMEOUT_MIN_CODE = 4'h0;
    localparam logic [3:0] TIMEOUT_MAX_CODE = 4'hf;
    // Effective operating mode, one-hot
    typedef enum logic [4:0] {
        MODE_SHUT  = 5'b00001,
        MODE_IND   = 5'b00010,
        MODE_TORCH = 5'b00100,
        MODE_FLASH = 5'b01000,
        MODE_VOLT  = 5'b10000
    } flm_mode_type;
endpackage
`default_nettype wire

// ### flm_mode_control.sv
// Notes on behaviour
// R1: Voltage bit and enables decode five modes
// R2: Indicator drives first sink only, fixed current
// R3: Voltage mode: sinks off, fixed-voltage boost
// R4: Sink mode from voltage mode enables both sinks
// R5: Headroom select: clear high, set low target
// R6: Multi pin: reset, general input or output
// R7: Low reset pin restores all power-on values
// R8: General input level captured on every write
// R9: Host leaves reset role before choosing output
// R10: General output drives pin-data bit, reset zero
// R11: Overvoltage select: one high, zero low
// R12: Current limit select: zero high, one low
// R13: Step field picks 25/50/100/200 us dwell
// R14: Code steps by one per step time
// R15: Torch level uses low five bits
// R16: Flash level seven bits, all ones full
// R17: Code plus one over 128, floor codes 0-4
// R18: Timeout 50 ms, 100 ms per code, 3200
// R19: Strobe flashes, transmit forces torch level
// R20: Flash ends on strobe low or timeout
// R21: Transmit drops to torch, returns within duration
// R22: After strobe flash, stored mode resumes
// R23: Safety timer keeps running during forced torch
`timescale 1ns/1ns
`default_nettype none
module flm_mode_control #(
    parameter int StepBaseCyc      = flm_pkg::STEP_BASE_CYC,     // Cycles per 25 us base step
    parameter int TimeoutUnitTicks = flm_pkg::TIMEOUT_UNIT_TICKS // Base steps per 50 ms unit
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       wrEn,
    input  wire logic [7:0] wrAddr,
    input  wire logic [7:0] wrData,
    input  wire logic       rdEn,
    input  wire logic [7:0] rdAddr,
    output logic      [7:0] rdData_r,
    input  wire logic       flashStrobePin,
    input  wire logic       txPin,
    input  wire logic       mfIn,
    output logic            mfOut_r,
    output logic            mfOe_r,
    output logic            sink1En_r,
    output logic            sink2En_r,
    output logic      [6:0] sinkCode_r,
    output logic            boostEn_r,
    output logic            fixedVoltage_r,
    output logic            headroomLow_r,
    output logic            ovpHigh_r,
    output logic            currentLimitLow_r,
    output logic            flashActive_r
);
    // Register bank
    logic [7:0] modeSelect_r;       // Mode enables, voltage bit, headroom select
    logic [7:0] multiPin_r;         // Multi pin role, direction, data, limits
    logic [7:0] stepTime_r;         // Ramp dwell per code
    logic [7:0] torchLevel_r;       // Torch current code
    logic [7:0] flashLevel_r;       // Flash current code
    logic [7:0] timeout_r;          // Flash safety timeout code

    // Timing and sequencing state
    logic [15:0] presc_r;           // Base-step divider
    logic        tick;              // One pulse per 25 us
    logic [3:0]  stepCnt_r;         // Base steps within one dwell
    logic        stepPulse;         // One pulse per dwell
    logic [17:0] flashCnt_r;        // Base steps spent in the current flash
    logic [17:0] flashLimit;        // Timeout in base steps
    logic        flashExpired_r;    // Timeout reached; held until request drops
    logic        flashReq;          // Strobe or stored flash selection
    logic        fromVolt_r;        // Sinks were entered from voltage mode
    flm_pkg::flm_mode_type modeR;   // Effective mode
    flm_pkg::flm_mode_type modeNxt; // Mode decoded for the next cycle
    logic [6:0]  target;            // Code the ramp is heading for

    // Field views
    logic [1:0] enCode;
    logic       resetRole;
    logic       gpoRole;
    logic       softReset;

    assign enCode    = modeSelect_r[flm_pkg::BIT_MODE_ENABLE_HI:flm_pkg::BIT_MODE_ENABLE_LO];
    assign resetRole = !multiPin_r[flm_pkg::BIT_RESET_SELECT];                       // see R6
    assign gpoRole   = !resetRole && multiPin_r[flm_pkg::BIT_PIN_DIRECTION];          // see R6
    // A low pin in its reset role acts like the chip reset for the register bank
    assign softReset = resetRole && !mfIn;                                            // see R7

    // Store only writable bits; reserved bits keep their power-on level
    function automatic logic [7:0] merge(input logic [7:0] d, input logic [7:0] m, input logic [7:0] r);
        merge = (d & m) | (r & ~m);
    endfunction

    // Dwell length in base steps: 1, 2, 4 or 8
    function automatic logic [3:0] stepTicks(input logic [1:0] st);
        stepTicks = 4'h1 << st;                                                       // see R13
    endfunction

    // Timeout in 50 ms units
    function automatic logic [6:0] timeoutUnits(input logic [3:0] fd);
        if (fd == flm_pkg::TIMEOUT_MIN_CODE) begin
            timeoutUnits = 7'(flm_pkg::TIMEOUT_MIN_MS / flm_pkg::TIMEOUT_UNIT_MS);    // see R18
        end else if (fd == flm_pkg::TIMEOUT_MAX_CODE) begin
            timeoutUnits = 7'(flm_pkg::TIMEOUT_FULL_MS / flm_pkg::TIMEOUT_UNIT_MS);   // see R18
        end else begin
            timeoutUnits = 7'(fd) * 7'(flm_pkg::TIMEOUT_STEP_MS / flm_pkg::TIMEOUT_UNIT_MS);
        end
    endfunction

    // Register writes; soft reset from the multi pin outranks a write
    always_ff @(posedge clk) begin
        if (!rstn || softReset) begin                                                 // see R7
            modeSelect_r <= flm_pkg::RST_MODE_SELECT;
            multiPin_r   <= flm_pkg::RST_MULTI_PIN;
            stepTime_r   <= flm_pkg::RST_STEP_TIME;
            torchLevel_r <= flm_pkg::RST_TORCH_LEVEL;
            flashLevel_r <= flm_pkg::RST_FLASH_LEVEL;
            timeout_r    <= flm_pkg::RST_TIMEOUT;
        end else if (wrEn) begin
            case (wrAddr)
                flm_pkg::ADDR_MODE_SELECT: begin
                    modeSelect_r <= merge(wrData, flm_pkg::MASK_MODE_SELECT, flm_pkg::RST_MODE_SELECT);
                end
                flm_pkg::ADDR_MULTI_PIN: begin
                    multiPin_r <= merge(wrData, flm_pkg::MASK_MULTI_PIN, flm_pkg::RST_MULTI_PIN);
                    // Leaving the reset role and choosing output takes two writes
                    if (resetRole) begin
                        multiPin_r[flm_pkg::BIT_PIN_DIRECTION] <= 1'b0;               // see R9
                    end
                    // Input role: the pin level replaces the written data bit
                    if (wrData[flm_pkg::BIT_RESET_SELECT] && (resetRole || !wrData[flm_pkg::BIT_PIN_DIRECTION])) begin
                        multiPin_r[flm_pkg::BIT_PIN_DATA] <= mfIn;                    // see R8
                    end
                end
                flm_pkg::ADDR_STEP_TIME: begin
                    stepTime_r <= merge(wrData, flm_pkg::MASK_STEP_TIME, flm_pkg::RST_STEP_TIME);
                end
                flm_pkg::ADDR_TORCH_LEVEL: begin
                    torchLevel_r <= merge(wrData, flm_pkg::MASK_LEVEL, flm_pkg::RST_TORCH_LEVEL);
                end
                flm_pkg::ADDR_FLASH_LEVEL: begin
                    flashLevel_r <= merge(wrData, flm_pkg::MASK_LEVEL, flm_pkg::RST_FLASH_LEVEL);
                end
                flm_pkg::ADDR_TIMEOUT: begin
                    timeout_r <= merge(wrData, flm_pkg::MASK_TIMEOUT, flm_pkg::RST_TIMEOUT);
                end
                default: begin
                    // Unmapped address: write dropped
                end
            endcase
            // Any other write still samples the pin in input role
            if (wrAddr != flm_pkg::ADDR_MULTI_PIN && !resetRole && !gpoRole) begin
                multiPin_r[flm_pkg::BIT_PIN_DATA] <= mfIn;                            // see R8
            end
        end
    end

    // Read data, one cycle after the request; unmapped reads give zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdData_r <= 8'h00;
        end else if (rdEn) begin
            case (rdAddr)
                flm_pkg::ADDR_MODE_SELECT: rdData_r <= modeSelect_r;
                flm_pkg::ADDR_MULTI_PIN:   rdData_r <= multiPin_r;
                flm_pkg::ADDR_STEP_TIME:   rdData_r <= stepTime_r;
                flm_pkg::ADDR_TORCH_LEVEL: rdData_r <= torchLevel_r;
                flm_pkg::ADDR_FLASH_LEVEL: rdData_r <= flashLevel_r;
                flm_pkg::ADDR_TIMEOUT:     rdData_r <= timeout_r;
                default:                   rdData_r <= 8'h00;
            endcase
        end
    end

    // Base-step divider: every slower rate comes from this pulse
    assign tick = (presc_r == 16'(StepBaseCyc - 1));
    always_ff @(posedge clk) begin
        if (!rstn || tick) begin
            presc_r <= 16'h0000;
        end else begin
            presc_r <= presc_r + 16'h0001;
        end
    end

    // Dwell counter; free running so a new ramp waits at most one dwell
    assign stepPulse = tick && (stepCnt_r >= stepTicks(stepTime_r[flm_pkg::STEP_W-1:0]) - 4'h1);
    always_ff @(posedge clk) begin
        if (!rstn || stepPulse) begin
            stepCnt_r <= 4'h0;
        end else if (tick) begin
            stepCnt_r <= stepCnt_r + 4'h1;                                            // see R13
        end
    end

    // Safety timer; it runs through transmit-forced torch as well
    assign flashReq   = flashStrobePin || (enCode == flm_pkg::EN_FLASH);
    assign flashLimit = 18'(timeoutUnits(timeout_r[flm_pkg::TIMEOUT_W-1:0])) * 18'(TimeoutUnitTicks);
    always_ff @(posedge clk) begin
        if (!rstn || !flashReq) begin
            flashCnt_r     <= 18'h00000;                                              // see R20
            flashExpired_r <= 1'b0;
        end else if (!flashExpired_r) begin
            if (flashCnt_r >= flashLimit) begin
                flashExpired_r <= 1'b1;                                               // see R18
            end else if (tick) begin
                flashCnt_r <= flashCnt_r + 18'h00001;                                 // see R23
            end
        end
    end

    // Mode decode from enables, voltage bit and the two pins
    always_comb begin
        modeNxt = flm_pkg::MODE_SHUT;
        if (flashReq && !flashExpired_r) begin
            // Transmit forces torch; flash resumes once it falls in time
            modeNxt = txPin ? flm_pkg::MODE_TORCH : flm_pkg::MODE_FLASH;              // see R19, R21
        end else begin
            // Stored mode takes over after a strobe flash or a timeout
            case (enCode)                                                             // see R1, R22
                flm_pkg::EN_INDICATOR: modeNxt = flm_pkg::MODE_IND;
                flm_pkg::EN_TORCH:     modeNxt = flm_pkg::MODE_TORCH;
                flm_pkg::EN_FLASH:     modeNxt = flm_pkg::MODE_SHUT;
                default: begin
                    modeNxt = modeSelect_r[flm_pkg::BIT_VOLTAGE_MODE] ? flm_pkg::MODE_VOLT : flm_pkg::MODE_SHUT;
                end
            endcase
        end
    end

    // Mode register and the memory of having come from voltage mode
    always_ff @(posedge clk) begin
        if (!rstn) begin
            modeR      <= flm_pkg::MODE_SHUT;
            fromVolt_r <= 1'b0;
        end else begin
            modeR <= modeNxt;
            case (modeR)
                flm_pkg::MODE_VOLT: fromVolt_r <= 1'b1;                               // see R4
                flm_pkg::MODE_SHUT: fromVolt_r <= 1'b0;
                default:            fromVolt_r <= fromVolt_r;
            endcase
        end
    end

    // Ramp target: torch uses only its low five bits, flash all seven
    always_comb begin
        case (modeR)
            flm_pkg::MODE_FLASH: target = flashLevel_r[flm_pkg::LEVEL_W-1:0];         // see R16
            flm_pkg::MODE_TORCH: target = 7'(torchLevel_r[flm_pkg::TORCH_USE_W-1:0]); // see R15
            flm_pkg::MODE_IND:   target = flm_pkg::INDICATOR_CODE;
            default:             target = 7'h00;
        endcase
    end

    // Current code ramp; the analog side maps it to (code+1)/128, floored at code 4
    always_ff @(posedge clk) begin
        if (!rstn || modeR == flm_pkg::MODE_VOLT) begin
            sinkCode_r <= 7'h00;                                                      // see R3
        end else if (stepPulse && sinkCode_r < target) begin
            sinkCode_r <= sinkCode_r + 7'h01;                                         // see R14, R17
        end else if (stepPulse && sinkCode_r > target) begin
            sinkCode_r <= sinkCode_r - 7'h01;                                         // see R14
        end
    end

    // Sink enables; sinks stay on while ramping down to zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sink1En_r <= 1'b0;
            sink2En_r <= 1'b0;
        end else begin
            case (modeR)
                flm_pkg::MODE_IND: begin
                    sink1En_r <= 1'b1;                                                // see R2
                    sink2En_r <= fromVolt_r;                                          // see R4
                end
                flm_pkg::MODE_TORCH, flm_pkg::MODE_FLASH: begin
                    sink1En_r <= 1'b1;
                    sink2En_r <= 1'b1;
                end
                flm_pkg::MODE_VOLT: begin
                    sink1En_r <= 1'b0;                                                // see R3
                    sink2En_r <= 1'b0;
                end
                default: begin
                    sink1En_r <= (sinkCode_r != 7'h00);
                    sink2En_r <= (sinkCode_r != 7'h00);
                end
            endcase
        end
    end

    // Converter controls and status outputs
    always_ff @(posedge clk) begin
        if (!rstn) begin
            boostEn_r         <= 1'b0;
            fixedVoltage_r    <= 1'b0;
            headroomLow_r     <= 1'b0;
            ovpHigh_r         <= 1'b0;
            currentLimitLow_r <= 1'b0;
            flashActive_r     <= 1'b0;
        end else begin
            boostEn_r         <= (modeR != flm_pkg::MODE_SHUT);
            fixedVoltage_r    <= (modeR == flm_pkg::MODE_VOLT);                       // see R3
            headroomLow_r     <= modeSelect_r[flm_pkg::BIT_HEADROOM_SELECT];          // see R5
            ovpHigh_r         <= multiPin_r[flm_pkg::BIT_OVERVOLTAGE_SEL];            // see R11
            currentLimitLow_r <= multiPin_r[flm_pkg::BIT_CURRENT_LIMIT];              // see R12
            flashActive_r     <= (modeR == flm_pkg::MODE_FLASH);
        end
    end

    // Multi pin driver; released in reset and input roles
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mfOut_r <= 1'b0;
            mfOe_r  <= 1'b0;
        end else begin
            mfOut_r <= gpoRole && multiPin_r[flm_pkg::BIT_PIN_DATA];                  // see R10
            mfOe_r  <= gpoRole;                                                       // see R6
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_ind_one_sink: assert property (modeR == flm_pkg::MODE_IND && !fromVolt_r |=> sink1En_r && !sink2En_r) // see R2
        else $error("indicator mode must use only the first sink");
    a_volt_sinks_off: assert property (modeR == flm_pkg::MODE_VOLT |=> !sink1En_r && !sink2En_r && fixedVoltage_r) // see R3
        else $error("voltage mode must turn both sinks off");
    a_volt_to_sink: assert property (modeR == flm_pkg::MODE_IND && fromVolt_r |=> sink1En_r && sink2En_r) // see R4
        else $error("sink mode after voltage mode must enable both sinks");
    // Strobe is looked at in the decode cycle itself; a later strobe may legally win
    a_stored_decode: assert property (!flashStrobePin && enCode == flm_pkg::EN_INDICATOR
                                      |=> modeR == flm_pkg::MODE_IND) // see R1
        else $error("indicator selection not decoded");
    a_tx_torch: assert property (flashStrobePin && txPin && !flashExpired_r |=> modeR == flm_pkg::MODE_TORCH) // see R19
        else $error("transmit during flash must give torch");
    a_timeout_end: assert property (flashReq && flashCnt_r >= flashLimit |-> ##2 modeR != flm_pkg::MODE_FLASH) // see R20
        else $error("flash outlived the safety timeout");
    a_ramp_step: assert property ($past(modeR) != flm_pkg::MODE_VOLT && sinkCode_r != $past(sinkCode_r)
                                  |-> $past(stepPulse) && (sinkCode_r == $past(sinkCode_r) + 7'h01
                                                           || sinkCode_r == $past(sinkCode_r) - 7'h01)) // see R14
        else $error("current code moved off a step boundary or by more than one");
    a_reset_pin: assert property (softReset |=> multiPin_r == flm_pkg::RST_MULTI_PIN
                                  && modeSelect_r == flm_pkg::RST_MODE_SELECT) // see R7
        else $error("reset pin did not restore power-on values");
    a_gpo_drive: assert property (gpoRole ##1 gpoRole |-> mfOe_r && mfOut_r == $past(multiPin_r[flm_pkg::BIT_PIN_DATA])) // see R10
        else $error("output role does not drive the data bit");
    a_gpi_capture: assert property (wrEn && wrAddr != flm_pkg::ADDR_MULTI_PIN && !resetRole && !gpoRole && !softReset
                                    |=> multiPin_r[flm_pkg::BIT_PIN_DATA] == $past(mfIn)) // see R8
        else $error("input role did not capture the pin on a write");
    a_headroom: assert property (##1 headroomLow_r == $past(modeSelect_r[flm_pkg::BIT_HEADROOM_SELECT])) // see R5
        else $error("headroom select not followed");

    c_strobe_flash: cover property (flashStrobePin && !txPin ##1 modeR == flm_pkg::MODE_FLASH);
    c_tx_in_flash:  cover property (modeR == flm_pkg::MODE_FLASH ##1 modeR == flm_pkg::MODE_TORCH && flashStrobePin);
    c_timeout:      cover property ($rose(flashExpired_r));
    c_volt_mode:    cover property (modeR == flm_pkg::MODE_VOLT);
endmodule // flm_mode_control
`default_nettype wire

// ### flm_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
// Host and imager side of the pins; levels change just after a clock edge
module flm_pin_model (
    input  wire logic clk,
    input  wire logic strobeCmd,
    input  wire logic txCmd,
    input  wire logic mfLevel,
    input  wire logic mfOut,
    input  wire logic mfOe,
    output var logic  flashStrobePin = 1'b0,
    output var logic  txPin = 1'b0,
    output logic      mfIn
);
    // Launch one edge after the command, like a remote driver would
    always @(posedge clk) begin
        flashStrobePin <= strobeCmd;
        txPin          <= txCmd;
    end
    // Shared pin: the device wins while it drives, else the host level
    assign mfIn = mfOe ? mfOut : mfLevel;
endmodule // flm_pin_model
`default_nettype wire

// ### test_flash_led_mode_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_flash_led_mode_control;
    logic       clk = 1'b0, rstn = 1'b0, wrEn = 1'b0, rdEn = 1'b0;
    logic       strobeCmd = 1'b0, txCmd = 1'b0, mfLevel = 1'b1;  // Pin kept high: normal use
    logic [7:0] wrAddr = 8'h00, wrData = 8'h00, rdAddr = 8'h00, rdData;
    logic       strobe, tx, mfIn, mfOut, mfOe, s1, s2, boost, fv, hrLow, ovpHi, clLow, fa;
    logic [6:0] code;
    int         fail_count = 0, cmp_count = 0, cycles = 0, n;
    logic [7:0] addrs [6] = '{8'h10, 8'h20, 8'h50, 8'ha0, 8'hb0, 8'hc0};
    logic [7:0] rsts  [6] = '{8'h18, 8'he0, 8'hfc, 8'h80, 8'h80, 8'hf0};
    logic [7:0] masks [6] = '{8'h27, 8'h1f, 8'h03, 8'h7f, 8'h7f, 8'h0f};
    // Short counts keep ramps and timeouts inside a quick run
    flm_mode_control #(.StepBaseCyc(4), .TimeoutUnitTicks(3)) i_dut (.clk(clk), .rstn(rstn), .wrEn(wrEn),
        .wrAddr(wrAddr), .wrData(wrData), .rdEn(rdEn), .rdAddr(rdAddr), .rdData_r(rdData),
        .flashStrobePin(strobe), .txPin(tx), .mfIn(mfIn), .mfOut_r(mfOut), .mfOe_r(mfOe), .sink1En_r(s1),
        .sink2En_r(s2), .sinkCode_r(code), .boostEn_r(boost), .fixedVoltage_r(fv), .headroomLow_r(hrLow),
        .ovpHigh_r(ovpHi), .currentLimitLow_r(clLow), .flashActive_r(fa));
    flm_pin_model i_pins (.clk(clk), .strobeCmd(strobeCmd), .txCmd(txCmd), .mfLevel(mfLevel), .mfOut(mfOut),
        .mfOe(mfOe), .flashStrobePin(strobe), .txPin(tx), .mfIn(mfIn));
    // 125 MHz clock
    initial forever #4 clk = ~clk;
    function automatic logic [7:0] outs();
        return {3'h0, boost, fv, s1, s2, fa};
    endfunction
    function automatic logic [7:0] pinv();
        return {4'h0, ovpHi, clLow, mfOe, mfOut};
    endfunction
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Write strobe held one cycle, then dropped
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wrEn <= 1'b1;
        wrAddr <= a;
        wrData <= d;
        @(posedge clk);
        wrEn <= 1'b0;
        repeat (6) @(negedge clk);
    endtask
    // Read data lands one cycle after the request edge
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rdEn <= 1'b1;
        rdAddr <= a;
        @(posedge clk);
        rdEn <= 1'b0;
        @(negedge clk);
        chk("readback", rdData, exp);
    endtask
    // Bounded wait for the ramp to reach a code
    task automatic waitcode(input logic [6:0] v);
        for (int i = 0; i < 400 && code !== v; i++) @(negedge clk);
        chk("sinkCode", {1'b0, code}, {1'b0, v});
    endtask
    task automatic pins(input logic s, input logic t);
        @(posedge clk);
        strobeCmd <= s;
        txCmd <= t;
        repeat (4) @(negedge clk);
    endtask
    // Hang guard: a stuck wait ends the run as a failure
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 6; i++) rdc(addrs[i], rsts[i]);
        for (int i = 2; i < 6; i++) begin
            wr(addrs[i], 8'h00);
            rdc(addrs[i], rsts[i] & ~masks[i]);
        end
        wr(8'h30, 8'hff);
        rdc(8'h30, 8'h00);
        $display("done: register table");
        wr(8'h10, 8'h04);
        chk("voltage", outs(), 8'h18);
        wr(8'h10, 8'h06);
        chk("fromVoltage", outs(), 8'h16);
        wr(8'h10, 8'h00);
        chk("shutdown", outs(), 8'h00);
        wr(8'h10, 8'h01);
        chk("indicator", outs(), 8'h14);
        wr(8'h10, 8'h21);
        chk("headroom", {7'h0, hrLow}, 8'h01);
        wr(8'h10, 8'h00);
        $display("done: mode decode");
        // Output requested straight from the reset role is held as input
        wr(8'h20, 8'h1b);
        chk("pinOneWrite", pinv(), 8'h0c);
        rdc(8'h20, 8'hfd);
        wr(8'h20, 8'h1b);
        chk("pinOut0", pinv(), 8'h0e);
        wr(8'h20, 8'h1f);
        chk("pinOut1", pinv(), 8'h0f);
        wr(8'h20, 8'h03);
        chk("pinLowSel", pinv(), 8'h02);
        wr(8'h20, 8'h01);
        wr(8'h20, 8'h01);
        rdc(8'h20, 8'he5);
        @(posedge clk) mfLevel <= 1'b0;
        wr(8'h50, 8'h00);
        rdc(8'h20, 8'he1);
        @(posedge clk) mfLevel <= 1'b1;
        wr(8'h20, 8'h00);
        wr(8'h10, 8'h02);
        @(posedge clk) mfLevel <= 1'b0;
        repeat (4) @(negedge clk);
        @(posedge clk) mfLevel <= 1'b1;
        rdc(8'h10, 8'h18);
        rdc(8'h20, 8'he0);
        $display("done: multi pin");
        for (int s = 0; s < 4; s++) begin
            wr(8'h50, 8'(s));
            wr(8'ha0, 8'h03);
            wr(8'h10, 8'h02);
            waitcode(7'h01);
            // The first step lands at an arbitrary divider phase; time a whole dwell
            waitcode(7'h02);
            for (n = 0; n < 255 && code === 7'h02; n++) @(negedge clk);
            chk("dwell", 8'(n), 8'(4 << s));
            wr(8'h10, 8'h00);
            waitcode(7'h00);
        end
        $display("done: step time");
        wr(8'h50, 8'h00);
        wr(8'ha0, 8'h02);
        wr(8'hb0, 8'h05);
        wr(8'hc0, 8'h0e);
        wr(8'h10, 8'h02);
        waitcode(7'h02);
        pins(1'b1, 1'b0);
        chk("flashOn", outs(), 8'h17);
        waitcode(7'h05);
        pins(1'b1, 1'b1);
        chk("txTorch", outs(), 8'h16);
        waitcode(7'h02);
        pins(1'b1, 1'b0);
        chk("txBack", outs(), 8'h17);
        pins(1'b0, 1'b0);
        chk("strobeEnd", outs(), 8'h16);
        waitcode(7'h02);
        wr(8'hc0, 8'h00);
        pins(1'b1, 1'b0);
        chk("timeoutStart", {7'h0, fa}, 8'h01);
        repeat (20) @(negedge clk);
        chk("timeout", {7'h0, fa}, 8'h00);
        pins(1'b0, 1'b0);
        wr(8'hc0, 8'h01);
        pins(1'b1, 1'b1);
        repeat (30) @(negedge clk);
        pins(1'b1, 1'b0);
        chk("timerInTorch", {7'h0, fa}, 8'h00);
        pins(1'b0, 1'b0);
        $display("done: flash sequence");
        summarize();
    end
endmodule // test_flash_led_mode_control
`default_nettype wire
